// ### hw/pct_pkg.sv
// Constants, field layout and mode types of the preset counter/timer core.
// Assumes a 125 MHz clock; all times are counted in 1 ms ticks.
package pct_pkg;
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;

  localparam int AW = 5;
  localparam int DW = 32;
  localparam int VW = 16;

  // Times in milliseconds
  localparam logic [15:0] START_DLY_MS = 16'h00F0;  // 240
  localparam logic [15:0] PWR_PV_MS    = 16'h0102;  // 258
  localparam logic [15:0] ACCUM_ERR_MS = 16'h0064;  // 100
  localparam logic [15:0] RST_SHORT_MS = 16'h0005;  // 5
  localparam logic [15:0] RST_LONG_MS  = 16'h0014;  // 20
  localparam logic [15:0] OUT_SLOW_MS  = 16'h0012;  // 18
  localparam logic [15:0] OUT_FAST_MS  = 16'h0004;  // 4
  localparam logic [15:0] COMMIT_MS    = 16'h07D0;  // 2000

  localparam logic [AW-1:0] ADDR_CTRL    = 5'h00;
  localparam logic [AW-1:0] ADDR_SETV    = 5'h04;
  localparam logic [AW-1:0] ADDR_PV      = 5'h08;
  localparam logic [AW-1:0] ADDR_STATUS  = 5'h0C;
  localparam logic [AW-1:0] ADDR_TOTAL   = 5'h10;
  localparam logic [AW-1:0] ADDR_CYCLE   = 5'h14;
  localparam logic [AW-1:0] ADDR_OUTTIME = 5'h18;
  localparam logic [AW-1:0] ADDR_PEND    = 5'h1C;

  localparam int CTRL_TIMER = 0;
  localparam int CTRL_CMODE = 1;
  localparam int CTRL_TREM  = 3;
  localparam int CTRL_STYLE = 4;
  localparam int CTRL_PWR   = 8;
  localparam int CTRL_RW20  = 9;
  localparam int CTRL_FAST  = 10;
  localparam int CTRL_W     = 11;

  localparam logic [10:0] CTRL_RESET    = 11'h000;
  localparam logic [15:0] SV_RESET      = 16'h0000;
  localparam logic [15:0] CYCLE_RESET   = 16'h03E8;
  localparam logic [15:0] OUTTIME_RESET = 16'h01F4;

  typedef enum logic [1:0] {CM_UP, CM_DOWN, CM_UPDOWN} pct_cmode_t;
  typedef enum logic [3:0] {OS_ONE, OS_TWO_SHOT, OS_TWO_HOLD, OS_THREE,
                            OS_FOUR, OS_ACCUM, OS_FLICKER, OS_SIX,
                            OS_SEVEN} pct_ostyle_t;
  typedef enum logic [1:0] {PU_SETTLE, PU_RUN} pct_pu_t;
endpackage

// ### hw/pct_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes every bit is an independent level; no bus coherency.
module pct_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pct_sync

// ### hw/pct_tick.sv
// Free-running divider giving a one-cycle pulse every N clocks.
// Assumes N of at least 2.
module pct_tick #(
  parameter int N = 125000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      tick
);
  localparam int CW = $clog2(N);
  localparam logic [CW-1:0] LAST = CW'(N - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt  <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule // pct_tick

// ### hw/pct_top.sv
// Control-output and timing core of a preset counter/timer.
// Assumes field pins are asynchronous and software uses the plain port.
// What this block does
// - Power-start timing waits 210-260 ms settle
// - Power-start display begins at 258 ms
// - Accumulative hold power start adds 100 ms error
// - Up or up/down counter: new set value equals count, output on
// - Elapsed timer: present at/above set acts reached
// - Remaining timer: set change shifts present value
// - Counter zero set: on at zero, off in reset
// - Zero set timer: on at start, listed styles
// - Zero set timer: stay off, other listed styles
// - Reset turns output off within configured delay
// - Styles six/seven output delay by speed setting
// - Key edits commit after 2 s or key
// - Counter reset: present to 0 or set value
// - Timer reset: stop, reload, force output off
//
// Decided for this implementation: the register offsets and the plain strobed port.
module pct_top
#(
  parameter int MS_CYCLES = pct_pkg::TICK_US * pct_pkg::CLK_MHZ
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [pct_pkg::AW-1:0] addr,
  input  wire logic [pct_pkg::DW-1:0] wdata,
  input  wire logic                  we,
  input  wire logic                  re,
  output logic      [pct_pkg::DW-1:0] rdata,
  input  wire logic                  count_in,
  input  wire logic                  dir_in,
  input  wire logic                  start_in,
  input  wire logic                  gate_in,
  input  wire logic                  reset_in,
  input  wire logic                  reset_key,
  input  wire logic                  key_level,
  input  wire logic                  key_mode,
  output logic                       ctrl_out
);
  import pct_pkg::*;

  logic [7:0]    pins_s;
  logic          ms_tick;
  logic          cnt_prev;
  logic          start_prev;
  logic          key_prev;
  logic [10:0]   ctrl;
  logic [VW-1:0] sv;
  logic [VW-1:0] sv_pend;
  logic          pend;
  logic [VW-1:0] idle_ms;
  logic [VW-1:0] cycle_ms;
  logic [VW-1:0] outtime_ms;
  logic [VW-1:0] pv;
  logic [DW-1:0] total;
  pct_pu_t       pu_state;
  logic [VW-1:0] pu_ms;
  logic          running;
  logic          reach_l;
  logic [VW-1:0] rst_ms;
  logic [VW-1:0] dly_ms;
  logic [VW-1:0] os_ms;
  logic [VW-1:0] phase_ms;

  pct_sync #(
    .W (8)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({count_in, dir_in, start_in, gate_in, reset_in, reset_key,
               key_level, key_mode}),
    .q       (pins_s)
  );

  pct_tick #(
    .N (MS_CYCLES)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick)
  );

  wire count_s = pins_s[7];
  wire dir_s   = pins_s[6];
  wire start_s = pins_s[5];
  wire gate_s  = pins_s[4];
  wire rst_raw = pins_s[3] | pins_s[2];
  wire key_s   = pins_s[1] | pins_s[0];

  wire         is_timer = ctrl[CTRL_TIMER];
  wire         t_rem    = ctrl[CTRL_TREM];
  wire         pwr_st   = ctrl[CTRL_PWR];
  pct_cmode_t  cmode;
  pct_ostyle_t style;
  assign cmode = pct_cmode_t'(ctrl[CTRL_CMODE +: 2]);
  assign style = pct_ostyle_t'(ctrl[CTRL_STYLE +: 4]);

  wire count_rise = count_s & ~cnt_prev;
  wire start_rise = start_s & ~start_prev;
  wire key_rise   = key_s & ~key_prev;
  wire started    = (pu_state == PU_RUN);

  // Reset only acts once it has been held for the configured width
  wire [VW-1:0] rst_lim = ctrl[CTRL_RW20] ? RST_LONG_MS : RST_SHORT_MS;
  wire          rst_eff = rst_raw && (rst_ms >= rst_lim);

  wire [VW-1:0] rst_val = (!is_timer && cmode == CM_DOWN) ? sv :
                          (is_timer && t_rem) ? sv : '0;

  // Commit on a level/mode key edge or after two idle seconds
  wire commit = pend && (key_rise || idle_ms >= COMMIT_MS);

  // Power start in accumulative hold loses part of the startup window
  wire [VW-1:0] pwr_pv = (style == OS_ACCUM) ?
                         PWR_PV_MS - ACCUM_ERR_MS : PWR_PV_MS;
  wire pwr_go = (pu_state == PU_SETTLE) && ms_tick &&
                (pu_ms + 16'h0001 >= START_DLY_MS);
  wire pwr_load = pwr_go && is_timer && pwr_st;

  wire cnt_ok = !is_timer && started && !rst_eff && count_rise &&
                (cmode == CM_UPDOWN || !dir_s);
  wire cnt_dn = (cmode == CM_DOWN) || (cmode == CM_UPDOWN && dir_s);
  wire tim_ok = is_timer && running && !rst_eff && !gate_s && ms_tick;

  logic [VW-1:0] next_pv;
  always_comb begin
    next_pv = pv;
    if (rst_eff) begin
      next_pv = rst_val;
    end else if (pwr_load) begin
      if (!t_rem) begin
        next_pv = pwr_pv;
      end else begin
        next_pv = (sv > pwr_pv) ? sv - pwr_pv : '0;
      end
    end else if (commit && is_timer && t_rem) begin
      // Shift by the set value change, clamped at zero
      if (sv_pend >= sv) begin
        next_pv = pv + (sv_pend - sv);
      end else begin
        next_pv = (pv > sv - sv_pend) ? pv - (sv - sv_pend) : '0;
      end
    end else if (cnt_ok) begin
      next_pv = cnt_dn ? pv - 16'h0001 : pv + 16'h0001;
    end else if (tim_ok) begin
      if (t_rem) begin
        next_pv = (pv != '0) ? pv - 16'h0001 : pv;
      end else begin
        next_pv = (pv != 16'hFFFF) ? pv + 16'h0001 : pv;
      end
    end
  end

  // Live compare: a changed set value is judged on the next cycle
  wire cnt_hit = (cmode == CM_DOWN) ? (pv == '0) : (pv == sv);
  wire tim_hit = running && (t_rem ? (pv == '0)
                                   : (pv >= sv));
  wire hit = started && !rst_eff && (is_timer ? tim_hit : cnt_hit);

  wire zero_off    = (style == OS_TWO_HOLD) || (style == OS_FOUR) ||
                     (style == OS_FLICKER);
  wire sv_zero_off = is_timer && (sv == '0) && zero_off;
  wire [VW-1:0] out_dly = ctrl[CTRL_FAST] ? OUT_FAST_MS : OUT_SLOW_MS;
  wire          delayed = (style == OS_SIX) || (style == OS_SEVEN);
  wire          one_shot = (style == OS_TWO_SHOT) || (style == OS_SEVEN);
  wire          dly_ok  = !delayed || (dly_ms >= out_dly);
  wire          os_live = os_ms < outtime_ms;

  logic next_out;
  always_comb begin
    next_out = 1'b0;
    if (started && !rst_eff && !sv_zero_off) begin
      unique case (style)
        OS_FOUR:    next_out = running && !reach_l;
        OS_FLICKER: next_out = running && (phase_ms < sv);
        default: begin
          if (one_shot) begin
            next_out = reach_l && dly_ok && os_live;
          end else begin
            next_out = reach_l && dly_ok;
          end
        end
      endcase
    end
  end

  wire sel_ctrl = (addr == ADDR_CTRL);
  wire sel_setv = (addr == ADDR_SETV);
  wire sel_cyc  = (addr == ADDR_CYCLE);
  wire sel_ot   = (addr == ADDR_OUTTIME);
  wire sel_tot  = (addr == ADDR_TOTAL);

  wire [DW-1:0] status = {26'h0000000, pend, rst_eff, started, running,
                          reach_l, ctrl_out};
  logic [DW-1:0] rd_mux;
  always_comb begin
    unique case (addr)
      ADDR_CTRL:    rd_mux = {21'h000000, ctrl};
      ADDR_SETV:    rd_mux = {16'h0000, sv};
      ADDR_PV:      rd_mux = {16'h0000, pv};
      ADDR_STATUS:  rd_mux = status;
      ADDR_TOTAL:   rd_mux = total;
      ADDR_CYCLE:   rd_mux = {16'h0000, cycle_ms};
      ADDR_OUTTIME: rd_mux = {16'h0000, outtime_ms};
      ADDR_PEND:    rd_mux = {16'h0000, sv_pend};
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= re ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl       <= CTRL_RESET;
      cycle_ms   <= CYCLE_RESET;
      outtime_ms <= OUTTIME_RESET;
    end else if (we) begin
      if (sel_ctrl) ctrl <= wdata[CTRL_W-1:0];
      if (sel_cyc)  cycle_ms <= wdata[VW-1:0];
      if (sel_ot)   outtime_ms <= wdata[VW-1:0];
    end
  end

  // A software write stands for one keypad edit and restarts idle time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sv      <= SV_RESET;
      sv_pend <= SV_RESET;
      pend    <= 1'b0;
      idle_ms <= '0;
    end else if (we && sel_setv) begin
      sv_pend <= wdata[VW-1:0];
      pend    <= 1'b1;
      idle_ms <= '0;
    end else if (commit) begin
      sv   <= sv_pend;
      pend <= 1'b0;
    end else if (pend && ms_tick) begin
      idle_ms <= idle_ms + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_prev   <= 1'b0;
      start_prev <= 1'b0;
      key_prev   <= 1'b0;
      pv         <= '0;
      ctrl_out   <= 1'b0;
    end else begin
      cnt_prev   <= count_s;
      start_prev <= start_s;
      key_prev   <= key_s;
      pv         <= next_pv;
      ctrl_out   <= next_out;
    end
  end

  // Totaliser keeps counting across present-value resets
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      total <= '0;
    end else if (we && sel_tot) begin
      total <= wdata;
    end else if (cnt_ok) begin
      total <= total + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_state <= PU_SETTLE;
      pu_ms    <= '0;
    end else if (pu_state == PU_SETTLE) begin
      if (pwr_go) begin
        pu_state <= PU_RUN;
      end else if (ms_tick) begin
        pu_ms <= pu_ms + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
    end else if (rst_eff || !is_timer) begin
      running <= 1'b0;
    end else if (pwr_load || (started && !pwr_st && start_rise)) begin
      running <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reach_l <= 1'b0;
    end else if (rst_eff) begin
      reach_l <= 1'b0;
    end else if (hit) begin
      reach_l <= 1'b1;
    end else if (!is_timer && cmode == CM_UPDOWN) begin
      reach_l <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_ms <= '0;
    end else if (!rst_raw) begin
      rst_ms <= '0;
    end else if (ms_tick && rst_ms != 16'hFFFF) begin
      rst_ms <= rst_ms + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_ms <= '0;
      os_ms  <= '0;
    end else if (!reach_l) begin
      dly_ms <= '0;
      os_ms  <= '0;
    end else if (ms_tick) begin
      if (!dly_ok) dly_ms <= dly_ms + 16'h0001;
      if (dly_ok && os_live) os_ms <= os_ms + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ms <= '0;
    end else if (!running) begin
      phase_ms <= '0;
    end else if (ms_tick) begin
      phase_ms <= (phase_ms + 16'h0001 >= cycle_ms) ? '0
                                                   : phase_ms + 16'h0001;
    end
  end
endmodule // pct_top

// ### test/pct_top_properties.sv
// Checker for the preset counter/timer core, bound to pct_top.
// Assumes one clock domain and the plain register port of the core.
module pct_top_checker
  import pct_pkg::*;
#(
  parameter int MS_CYCLES = 125000
) (
  input wire logic          clk,
  input wire logic          reset_n,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic          we,
  input wire logic          re,
  input wire logic [DW-1:0] rdata,
  input wire logic          count_in,
  input wire logic          dir_in,
  input wire logic          start_in,
  input wire logic          gate_in,
  input wire logic          reset_in,
  input wire logic          reset_key,
  input wire logic          key_level,
  input wire logic          key_mode,
  input wire logic          ctrl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // One tick of slack: the ms divider phase is unknown
  localparam int PU_LIM = 239 * MS_CYCLES;
  // Longest reset width plus sync and output register
  localparam int RST_LIM = 21 * MS_CYCLES + 6;
  int pu_cnt;
  int hold_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt <= 0;
      hold_cnt <= 0;
    end else begin
      if (pu_cnt < PU_LIM) pu_cnt <= pu_cnt + 1;
      if (!(reset_in | reset_key)) hold_cnt <= 0;
      else if (hold_cnt <= RST_LIM) hold_cnt <= hold_cnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  rd_idle_zero_a: assert property (!$past(re) |-> rdata == 32'h0)
    else $error("read data not zero outside an answer");
  unmapped_zero_a: assert property (re && addr == 5'h02 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_upper_a: assert property (re && addr == ADDR_CTRL |=>
    rdata[31:11] == 21'h0) else $error("control upper bits not zero");
  pv_upper_a: assert property (re && addr == ADDR_PV |=>
    rdata[31:16] == 16'h0) else $error("present value upper bits set");
  total_rw_a: assert property (we && addr == ADDR_TOTAL ##1
    re && addr == ADDR_TOTAL |=> rdata == $past(wdata, 2))
    else $error("total read back differs");
  pend_cap_a: assert property (we && addr == ADDR_SETV ##1
    re && addr == ADDR_PEND |=> rdata[15:0] == $past(wdata[15:0], 2))
    else $error("pending set value not captured");
  status_out_a: assert property (re && addr == ADDR_STATUS |=>
    rdata[0] == $past(ctrl_out)) else $error("status output bit differs");
  startup_off_a: assert property (pu_cnt < PU_LIM |-> !ctrl_out)
    else $error("output on before startup delay");
  reset_off_a: assert property (hold_cnt > RST_LIM |-> !ctrl_out)
    else $error("output on while reset held");
  cover property ($rose(ctrl_out));
  cover property (hold_cnt > RST_LIM);
  cover property (we && addr == ADDR_SETV);
endmodule // pct_top_checker

bind pct_top pct_top_checker #(.MS_CYCLES(MS_CYCLES)) pct_top_checker_inst (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .we(we),
  .re(re), .rdata(rdata), .count_in(count_in), .dir_in(dir_in),
  .start_in(start_in), .gate_in(gate_in), .reset_in(reset_in),
  .reset_key(reset_key), .key_level(key_level), .key_mode(key_mode),
  .ctrl_out(ctrl_out));

// ### test/pct_field.sv
// Field sensors and front keys facing the counter/timer core.
// Assumes the bench calls hold just after a rising clock edge.
module pct_field (
  input wire logic clk,
  output logic     count_in,
  output logic     dir_in,
  output logic     start_in,
  output logic     gate_in,
  output logic     reset_in,
  output logic     reset_key,
  output logic     key_level,
  output logic     key_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pins = 6'h00;
  assign {key_mode, key_level, reset_key, reset_in, start_in, count_in} = pins;
  // Count is never prohibited and timing never gated here
  assign dir_in = 1'b0;
  assign gate_in = 1'b0;
  // Pin 0 count, 1 start, 2 reset, 3 reset key, 4 level key, 5 mode key
  // Reset holds are asked for at least the configured width
  task automatic hold(input int sel, input int clks);
    @(posedge clk);
    pins[sel] <= 1'b1;
    repeat (clks) @(posedge clk);
    pins[sel] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // pct_field

// ### test/tb.sv
// Self-checking bench for the preset counter/timer core.
// Assumes a 1 ms tick shortened to 10 clocks through MS_CYCLES.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pct_pkg::*;
  localparam int MS = 10;
  localparam logic [AW-1:0] RA [6] = '{ADDR_CTRL, ADDR_SETV, ADDR_CYCLE,
    ADDR_OUTTIME, 5'h02, ADDR_PV};
  localparam logic [31:0] RV [6] = '{32'h0, 32'h0, 32'h3E8, 32'h1F4,
    32'h0, 32'h0};
  localparam logic [31:0] TS [7] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4,
    32'h5, 32'h6};
  localparam logic [6:0] TE = 7'b0101011;
  logic clk, reset_n, we, re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, val;
  logic count_in, dir_in, start_in, gate_in, reset_in, reset_key;
  logic key_level, key_mode, ctrl_out;
  int mismatches = 0;
  int checks_done = 0;
  pct_top #(.MS_CYCLES(MS)) pct_top_inst (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .count_in(count_in), .dir_in(dir_in), .start_in(start_in),
    .gate_in(gate_in), .reset_in(reset_in), .reset_key(reset_key),
    .key_level(key_level), .key_mode(key_mode), .ctrl_out(ctrl_out));
  pct_field pct_field_inst (.clk(clk), .count_in(count_in),
    .dir_in(dir_in), .start_in(start_in), .gate_in(gate_in),
    .reset_in(reset_in), .reset_key(reset_key), .key_level(key_level),
    .key_mode(key_mode));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic compare(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Look mid-cycle so the value launched at the last edge has settled
  task automatic cout(input logic [31:0] exp);
    @(negedge clk);
    compare("ctrl_out", exp, {31'h0, ctrl_out});
    @(posedge clk);
  endtask
  // A write leaves one idle cycle so two writes never meet in a step
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    val = rdata;
    @(posedge clk);
  endtask
  task automatic wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d,
                       input logic [AW-1:0] ra);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    rd(ra);
  endtask
  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog expected end seen hang");
    conclude;
  end
  initial begin
    reset_n = 1'b0;
    we = 1'b0;
    re = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd(RA[i]);
      compare("reset value", RV[i], val);
    end
    wr_rd(ADDR_TOTAL, 32'hA5C30F12, ADDR_TOTAL);
    compare("total", 32'hA5C30F12, val);
    wr_rd(ADDR_SETV, 32'h7, ADDR_PEND);
    compare("pending", 32'h7, val);
    ms(226);
    cout(32'h0);
    ms(19);
    cout(32'h1);
    rd(ADDR_STATUS);
    compare("status", 32'h1, {31'h0, val[0]});
    $display("test startup done");
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_CTRL, w ? 32'h200 : 32'h0);
      fork
        pct_field_inst.hold(2 + w, (w ? 30 : 12) * MS);
      join_none
      ms(w ? 18 : 3);
      cout(32'h1);
      ms(4);
      cout(32'h0);
      wait fork;
      ms(3);
      cout(32'h1);
    end
    $display("test reset width done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SETV, 32'h3);
    pct_field_inst.hold(4, 3);
    rd(ADDR_SETV);
    compare("set value", 32'h3, val);
    pct_field_inst.hold(2, 8 * MS);
    repeat (2) pct_field_inst.hold(0, 4);
    cout(32'h0);
    wr(ADDR_SETV, 32'h2);
    pct_field_inst.hold(5, 3);
    repeat (2) @(posedge clk);
    cout(32'h1);
    fork
      pct_field_inst.hold(2, 10 * MS);
    join_none
    ms(7);
    pct_field_inst.hold(0, 4);
    rd(ADDR_PV);
    compare("pv in reset", 32'h0, val);
    wait fork;
    rd(ADDR_PV);
    compare("pv after reset", 32'h0, val);
    rd(ADDR_TOTAL);
    compare("total kept", 32'hA5C30F14, val);
    wr(ADDR_CTRL, 32'h2);
    pct_field_inst.hold(2, 8 * MS);
    rd(ADDR_PV);
    compare("pv down", 32'h2, val);
    $display("test counter done");
    wr(ADDR_SETV, 32'h0);
    pct_field_inst.hold(5, 3);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CTRL, 32'h1 | (TS[i] << 4));
      pct_field_inst.hold(2, 8 * MS);
      pct_field_inst.hold(1, 4);
      ms(2);
      cout({31'h0, TE[i]});
    end
    $display("test timer zero done");
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_SETV, 32'h4);
    ms(1000);
    rd(ADDR_SETV);
    compare("set value held", 32'h0, val);
    ms(1005);
    rd(ADDR_SETV);
    compare("set value idle", 32'h4, val);
    pct_field_inst.hold(2, 8 * MS);
    pct_field_inst.hold(1, 4);
    ms(8);
    cout(32'h1);
    wr(ADDR_SETV, 32'h32);
    pct_field_inst.hold(4, 3);
    pct_field_inst.hold(2, 8 * MS);
    pct_field_inst.hold(1, 4);
    ms(10);
    cout(32'h0);
    wr(ADDR_SETV, 32'h5);
    pct_field_inst.hold(4, 3);
    ms(1);
    cout(32'h1);
    $display("test timer live done");
    wr(ADDR_CTRL, 32'h9);
    pct_field_inst.hold(2, 8 * MS);
    rd(ADDR_PV);
    compare("pv remaining reset", 32'h5, val);
    wr(ADDR_SETV, 32'h8);
    pct_field_inst.hold(4, 3);
    rd(ADDR_PV);
    compare("pv shifted up", 32'h8, val);
    wr(ADDR_SETV, 32'h6);
    pct_field_inst.hold(5, 3);
    rd(ADDR_PV);
    compare("pv shifted down", 32'h6, val);
    $display("test remaining done");
    wr(ADDR_CTRL, 32'h471);
    pct_field_inst.hold(2, 8 * MS);
    pct_field_inst.hold(1, 4);
    ms(7);
    cout(32'h0);
    ms(6);
    cout(32'h1);
    $display("test output delay done");
    for (int p = 0; p < 2; p++) begin
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      wr(ADDR_CTRL, p ? 32'h151 : 32'h101);
      wr(ADDR_SETV, 32'hC8);
      pct_field_inst.hold(4, 3);
      ms(233);
      cout(32'h0);
      ms(12);
      cout({31'h0, p == 0});
      ms(45);
      cout(32'h1);
    end
    $display("test power start done");
    conclude;
  end
endmodule // tb
